// file: fifo_queue_pkg.sv
// Constants, register map and carrier types for the configurable queue
package fifo_queue_pkg;

  // Register bus layout
  localparam int         AXI_AW        = 8;
  localparam int         AXI_DW        = 32;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] REG_COUNT     = 8'h10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Control register fields
  localparam int         CTRL_THRU_BIT = 0;
  localparam logic       CTRL_THRU_RST = 1'h0;

  // Status register fields
  localparam int         ST_EMPTY_BIT  = 0;
  localparam int         ST_FULL_BIT   = 1;
  localparam int         ST_NE_BIT     = 2;
  localparam int         ST_NF_BIT     = 3;
  localparam int         ST_BLK_BIT    = 4;

  // Interrupt fields
  localparam int         IRQ_W         = 4;
  localparam logic [3:0] IRQ_MASK_RST  = 4'h0;

  // Timing
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         BLACKOUT_CYC  = 20;
  localparam int         RST_LATENCY   = 1;

  // Sticky queue events, overflow in bit 0
  typedef struct packed {
    logic empty_hit;
    logic full_hit;
    logic underflow;
    logic overflow;
  } irq_ev_t;

  // Queue fill state
  typedef struct packed {
    logic blackout;
    logic nearly_full;
    logic nearly_empty;
    logic full;
    logic empty;
  } fill_state_t;

endpackage : fifo_queue_pkg

// file: configurable_fifo_queue.sv
// Configurable first-in first-out queue with AXI4-Lite control and status
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps

// Overview of operation
// - A write with enable stores the input word in the next free slot.
// - Standard mode updates read data only when the consumer asserts read enable.
// - Words leave in exactly the order they were stored.
// - Full flag is high whenever every slot holds a word.
// - Empty flag is high whenever no word is stored.
// - Fill fraction is count over depth, binary point above its top bit.
// - Fill fraction output exists by default; a parameter can remove it.
// - Fall-through mode shows the oldest word unasked whenever data is present.
// - Output pipeline option adds exactly one cycle to read data and valid.
// - With the pipeline option, reset loads read data with a chosen value.
// - Depth is configurable from 16 up to 64K words.
// - Optional reset input passes through a configurable register chain, default one.
// - Reads and writes are ignored for 20 cycles after reset.
// - Optional word count output reports the number of stored words.
// - Nearly-empty and nearly-full flag outputs are each optional by parameter.
module configurable_fifo_queue #(
  parameter int          DATA_W   = 16,
  parameter int          DEPTH    = 16,
  parameter int          FRAC_W   = 1,
  parameter bit          PIPE_OUT = 1'b0,
  parameter int          RST_LAT  = fifo_queue_pkg::RST_LATENCY,
  parameter int          BLACKOUT = fifo_queue_pkg::BLACKOUT_CYC,
  parameter bit          HAS_RST  = 1'b1,
  parameter bit          HAS_EN   = 1'b1,
  parameter bit          HAS_FRAC = 1'b1,
  parameter bit          HAS_CNT  = 1'b1,
  parameter bit          HAS_NE   = 1'b1,
  parameter bit          HAS_NF   = 1'b1,
  parameter [DATA_W-1:0] DOUT_RST = '0
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              fifo_rst,
  input  wire logic                              en,
  input  wire logic                              wr_en,
  input  wire logic [DATA_W-1:0]                 wr_data,
  input  wire logic                              rd_en,
  output logic      [DATA_W-1:0]                 rd_data,
  output logic                                   rd_valid,
  output logic                                   full,
  output logic                                   empty,
  output logic      [FRAC_W-1:0]                 fill_frac,
  output logic      [$clog2(DEPTH):0]            data_count,
  output logic                                   nearly_empty_flag,
  output logic                                   nearly_full_flag,
  output logic                                   irq,
  input  wire logic [fifo_queue_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [fifo_queue_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic      [1:0]                        s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [fifo_queue_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic      [fifo_queue_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic      [1:0]                        s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);

  localparam int          ADDR_W = $clog2(DEPTH);
  localparam int          CNT_W  = ADDR_W + 1;
  localparam int          BLK_W  = $clog2(BLACKOUT + 1) + 1;
  localparam int          RL     = RST_LAT;
  localparam [CNT_W-1:0]  CNT_FULL = CNT_W'(DEPTH);
  localparam [CNT_W-1:0]  CNT_ONE  = CNT_W'(1);
  localparam [BLK_W-1:0]  BLK_LOAD = BLK_W'(BLACKOUT);

  // Fill fraction, saturating at all ones when full
  function automatic logic [FRAC_W-1:0] frac_of(input logic [CNT_W-1:0] c);
    frac_of = c[ADDR_W] ? {FRAC_W{1'b1}} : c[ADDR_W-1 -: FRAC_W];
  endfunction : frac_of

  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c,
                                            input logic up, input logic dn);
    step = c + CNT_W'(up) - CNT_W'(dn);
  endfunction : step

  // Reset chain and blackout
  logic [RL-1:0]      rst_chain_r;
  logic [BLK_W-1:0]   blk_cnt_r;
  logic               core_rst;
  logic               blackout;

  assign core_rst = !aresetn || rst_chain_r[RL-1];
  assign blackout = (blk_cnt_r != '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_chain_r <= '1;
    end else begin
      rst_chain_r <= RL'({rst_chain_r, HAS_RST && fifo_rst});
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      blk_cnt_r <= BLK_LOAD;
    end else if (blackout) begin
      blk_cnt_r <= blk_cnt_r - BLK_W'(1);
    end
  end

  // Storage and pointers
  logic [DATA_W-1:0]  mem [DEPTH];
  logic [ADDR_W-1:0]  wr_ptr_r;
  logic [ADDR_W-1:0]  rd_ptr_r;
  logic [CNT_W-1:0]   count_r;
  logic [CNT_W-1:0]   count_nxt;
  logic [ADDR_W-1:0]  rd_ptr_nxt;
  logic               fall_through_mode_r;
  logic               run;
  logic               push;
  logic               pop;
  logic [DATA_W-1:0]  head_q;
  logic [DATA_W-1:0]  next_head;
  logic [DATA_W-1:0]  core_dout_r;
  logic               core_valid_r;
  logic [DATA_W-1:0]  pipe_dout_r;
  logic               pipe_valid_r;

  assign run        = (!HAS_EN || en) && !core_rst && !blackout;
  assign full       = (count_r == CNT_FULL);
  assign empty      = (count_r == '0);
  assign push       = run && wr_en && !full;
  assign pop        = run && rd_en && !empty;
  assign count_nxt  = step(count_r, push, pop);
  assign rd_ptr_nxt = rd_ptr_r + ADDR_W'(pop);
  assign head_q     = mem[rd_ptr_r];
  assign next_head  = (push && wr_ptr_r == rd_ptr_nxt) ? wr_data : mem[rd_ptr_nxt];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + ADDR_W'(push);
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // Output word: on request in standard mode, head tracking in fall-through
  always_ff @(posedge aclk) begin
    if (core_rst) begin
      core_dout_r  <= DOUT_RST;
      core_valid_r <= 1'b0;
    end else if (!HAS_EN || en) begin
      if (fall_through_mode_r) begin
        core_dout_r  <= next_head;
        core_valid_r <= (count_nxt != '0);
      end else begin
        core_valid_r <= pop;
        if (pop) begin
          core_dout_r <= head_q;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (core_rst) begin
      pipe_dout_r  <= DOUT_RST;
      pipe_valid_r <= 1'b0;
    end else if (!HAS_EN || en) begin
      pipe_dout_r  <= core_dout_r;
      pipe_valid_r <= core_valid_r;
    end
  end

  assign rd_data           = PIPE_OUT ? pipe_dout_r : core_dout_r;
  assign rd_valid          = PIPE_OUT ? pipe_valid_r : core_valid_r;
  assign fill_frac         = HAS_FRAC ? frac_of(count_r) : '0;
  assign data_count        = HAS_CNT ? count_r : '0;
  assign nearly_empty_flag = HAS_NE && (count_r == CNT_ONE);
  assign nearly_full_flag  = HAS_NF && (count_r == CNT_FULL - CNT_ONE);

  // Events and interrupt
  localparam int               IRQ_W_L = fifo_queue_pkg::IRQ_W;
  fifo_queue_pkg::irq_ev_t     ev;
  fifo_queue_pkg::fill_state_t fs;
  logic [IRQ_W_L-1:0]          irq_stat_r;
  logic [IRQ_W_L-1:0]          irq_stat_nxt;
  logic [IRQ_W_L-1:0]          irq_mask_r;
  logic                        stat_clr;

  assign ev.overflow  = run && wr_en && full && !pop;
  assign ev.underflow = run && rd_en && empty;
  assign ev.full_hit  = (count_r != CNT_FULL) && (count_nxt == CNT_FULL);
  assign ev.empty_hit = (count_r != '0) && (count_nxt == '0);
  assign fs           = '{blackout: blackout, nearly_full: nearly_full_flag,
                          nearly_empty: nearly_empty_flag, full: full, empty: empty};
  assign irq_stat_nxt = (irq_stat_r & ~{IRQ_W_L{stat_clr}}) | ev;
  assign irq          = |(irq_stat_r & irq_mask_r);

  // AXI4-Lite slave
  logic                              aw_held_r;
  logic                              w_held_r;
  logic [fifo_queue_pkg::AXI_AW-1:0] awaddr_r;
  logic [fifo_queue_pkg::AXI_DW-1:0] wdata_r;
  logic [3:0]                        wstrb_r;
  logic                              bvalid_r;
  logic [1:0]                        bresp_r;
  logic                              rvalid_r;
  logic [1:0]                        rresp_r;
  logic [fifo_queue_pkg::AXI_DW-1:0] rdata_r;
  logic                              aw_take;
  logic                              w_take;
  logic                              ar_take;
  logic                              do_write;
  logic [fifo_queue_pkg::AXI_AW-1:0] wa;
  logic [fifo_queue_pkg::AXI_DW-1:0] wd;
  logic [3:0]                        ws;
  logic                              wr_ctrl;
  logic                              wr_mask;
  logic                              wr_hit;
  logic                              rd_hit;
  logic [fifo_queue_pkg::AXI_DW-1:0] rd_word;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign do_write = (aw_held_r || aw_take) && (w_held_r || w_take);
  assign wa       = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wd       = w_held_r ? wdata_r : s_axi_wdata;
  assign ws       = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_ctrl  = do_write && wa == fifo_queue_pkg::REG_CTRL && ws[0];
  assign wr_mask  = do_write && wa == fifo_queue_pkg::REG_IRQ_MASK && ws[0];
  assign wr_hit   = wa == fifo_queue_pkg::REG_CTRL || wa == fifo_queue_pkg::REG_IRQ_MASK;
  assign stat_clr = ar_take && s_axi_araddr == fifo_queue_pkg::REG_IRQ_STAT;
  assign rd_hit   = s_axi_araddr inside {fifo_queue_pkg::REG_CTRL, fifo_queue_pkg::REG_STATUS,
                    fifo_queue_pkg::REG_IRQ_STAT, fifo_queue_pkg::REG_IRQ_MASK,
                    fifo_queue_pkg::REG_COUNT};
  assign rd_word  =
    (s_axi_araddr == fifo_queue_pkg::REG_CTRL)     ? 32'(fall_through_mode_r) :
    (s_axi_araddr == fifo_queue_pkg::REG_STATUS)   ? 32'(fs) :
    (s_axi_araddr == fifo_queue_pkg::REG_IRQ_STAT) ? 32'(irq_stat_r) :
    (s_axi_araddr == fifo_queue_pkg::REG_IRQ_MASK) ? 32'(irq_mask_r) :
    (s_axi_araddr == fifo_queue_pkg::REG_COUNT)    ? 32'(count_r) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_through_mode_r <= fifo_queue_pkg::CTRL_THRU_RST;
      irq_mask_r <= fifo_queue_pkg::IRQ_MASK_RST;
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_ctrl) begin
        fall_through_mode_r <= wd[fifo_queue_pkg::CTRL_THRU_BIT];
      end
      if (wr_mask) begin
        irq_mask_r <= wd[IRQ_W_L-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= fifo_queue_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_held_r <= !do_write && (aw_held_r || aw_take);
      w_held_r  <= !do_write && (w_held_r || w_take);
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? fifo_queue_pkg::RESP_OKAY : fifo_queue_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= fifo_queue_pkg::RESP_OKAY;
      rdata_r  <= '0;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? fifo_queue_pkg::RESP_OKAY : fifo_queue_pkg::RESP_SLVERR;
      rdata_r  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rst_release;
    core_rst ##1 !core_rst;
  endsequence

  property p_store;
    push |=> mem[$past(wr_ptr_r)] == $past(wr_data);
  endproperty
  a_store: assert property (p_store) else $error("stored word differs");

  property p_std_read;
    (!fall_through_mode_r && pop) |=> core_valid_r && core_dout_r == $past(head_q);
  endproperty
  a_std_read: assert property (p_std_read) else $error("read word wrong");

  property p_std_idle;
    (!fall_through_mode_r && !pop && !core_rst && (!HAS_EN || en)) |=>
      !core_valid_r && $stable(core_dout_r);
  endproperty
  a_std_idle: assert property (p_std_idle) else $error("output moved unasked");

  property p_full;
    (count_r == CNT_FULL - CNT_ONE && push && !pop) |=> full && !empty;
  endproperty
  a_full: assert property (p_full) else $error("full not raised");

  property p_empty;
    (count_r == CNT_ONE && pop && !push) |=> empty ##1 (empty || $past(push));
  endproperty
  a_empty: assert property (p_empty) else $error("empty not raised");

  property p_fall_through;
    (fall_through_mode_r && !empty && !pop && !core_rst && (!HAS_EN || en)) |=> core_valid_r;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("head word not shown");

  property p_pipe;
    (!core_rst && (!HAS_EN || en)) |=> pipe_valid_r == $past(core_valid_r);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline delay wrong");

  property p_pipe_rst;
    core_rst |=> pipe_dout_r == DOUT_RST;
  endproperty
  a_pipe_rst: assert property (p_pipe_rst) else $error("reset value missing");

  property p_blackout;
    s_rst_release |-> (!push && !pop)[*8];
  endproperty
  a_blackout: assert property (p_blackout) else $error("access during blackout");

  property p_rst_lat;
    (HAS_RST && fifo_rst) |-> ##RL core_rst;
  endproperty
  a_rst_lat: assert property (p_rst_lat) else $error("reset latency wrong");

  property p_count;
    !core_rst |=> count_r == $past(count_nxt) && count_r <= CNT_FULL;
  endproperty
  a_count: assert property (p_count) else $error("count wrong");

  property p_overflow;
    (full && wr_en && !pop) |=> $stable(wr_ptr_r) && count_r == CNT_FULL;
  endproperty
  a_overflow: assert property (p_overflow) else $error("write while full took effect");

  property p_hold;
    (HAS_EN && !en && !core_rst) |=> $stable(count_r) && $stable(rd_ptr_r);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while disabled");

endmodule : configurable_fifo_queue

// file: stream_partner.sv
// Producer and consumer model on the queue's data side
`timescale 1ns/1ps
module stream_partner #(
  parameter int DATA_W = 16
) (
  input  wire logic              aclk,
  input  wire logic [DATA_W-1:0] rd_data,
  input  wire logic              rd_valid,
  output logic                   wr_en,
  output logic      [DATA_W-1:0] wr_data,
  output logic                   rd_en
);
  initial begin
    wr_en   = 1'b0;
    wr_data = '0;
    rd_en   = 1'b0;
  end

  // Back-to-back words, one per cycle
  task automatic push_burst(input int n, input logic [DATA_W-1:0] base);
    @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      wr_en   <= 1'b1;
      wr_data <= base + DATA_W'(i);
      @(posedge aclk);
    end
    wr_en   <= 1'b0;
    wr_data <= ~(base + DATA_W'(n - 1));
  endtask : push_burst

  // Back-to-back reads, keeps each word shown with valid
  task automatic pop_burst(input int n, output logic [DATA_W-1:0] got[$]);
    got = {};
    @(posedge aclk);
    rd_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      if (i == n - 1) rd_en <= 1'b0;
      #1;
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
  endtask : pop_burst
endmodule : stream_partner

// file: configurable_fifo_queue_test.sv
// Self-checking testbench for the configurable queue
`timescale 1ns/1ps
module configurable_fifo_queue_test;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        fifo_rst = 1'b0;
  logic        en = 1'b1;
  logic        wr_en, rd_en, rd_valid, full, empty, irq;
  logic [15:0] wr_data, rd_data;
  logic [0:0]  fill_frac;
  logic [4:0]  data_count;
  logic        nearly_empty_flag, nearly_full_flag;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rd_v;
  logic [1:0]  resp;
  logic [15:0] got[$];
  int          err_count = 0;
  int          comparisons = 0;

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  configurable_fifo_queue #(.DATA_W(16), .DEPTH(16)) DUT (
    .aclk(aclk), .aresetn(aresetn), .fifo_rst(fifo_rst), .en(en), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .full(full), .empty(empty), .fill_frac(fill_frac), .data_count(data_count),
    .nearly_empty_flag(nearly_empty_flag), .nearly_full_flag(nearly_full_flag),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  stream_partner #(.DATA_W(16)) partner (
    .aclk(aclk), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));

  task automatic end_of_test;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus_wait(inout int n);
    n++;
    if (n > 200) begin
      err_count++;
      end_of_test();
    end
  endtask : bus_wait

  // Write: address and data offered together, response ends it
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    int   n;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb) begin
      bus_wait(n);
      @(negedge aclk);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      tb = (bvalid === 1'b1);
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int   n;
    n = 0;
    tr = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr) begin
      bus_wait(n);
      @(negedge aclk);
      ta = arvalid && (arready === 1'b1);
      tr = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : axi_read

  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_read(a, rd_v, resp);
    check("register read", rd_v, exp);
    check("read response", {30'h0, resp}, {30'h0, er});
  endtask : read_chk

  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    partner.push_burst(1, 16'hA000);
    #1 check("count in blackout", data_count, 32'h0);
    read_chk(fifo_queue_pkg::REG_STATUS, 32'h11, fifo_queue_pkg::RESP_OKAY);
    read_chk(fifo_queue_pkg::REG_CTRL, 32'h0, fifo_queue_pkg::RESP_OKAY);
    read_chk(fifo_queue_pkg::REG_IRQ_MASK, 32'h0, fifo_queue_pkg::RESP_OKAY);
    repeat (25) @(posedge aclk);
    axi_write(fifo_queue_pkg::REG_IRQ_MASK, 32'h1, resp);
    check("mask write response", resp, fifo_queue_pkg::RESP_OKAY);
    partner.push_burst(7, 16'h1000);
    #1 check("fraction at 7", fill_frac, 32'h0);
    partner.push_burst(1, 16'h1007);
    #1 check("fraction at 8", fill_frac, 32'h1);
    partner.push_burst(7, 16'h1008);
    #1 check("nearly full", {full, nearly_full_flag}, 32'h1);
    partner.push_burst(1, 16'h100F);
    #1 check("full flag", {full, empty}, 32'h2);
    check("count full", data_count, 32'h10);
    check("irq before overflow", irq, 32'h0);
    partner.push_burst(1, 16'hBEEF);
    repeat (2) @(posedge aclk);
    #1 check("count after overflow", data_count, 32'h10);
    check("irq on overflow", irq, 32'h1);
    read_chk(fifo_queue_pkg::REG_IRQ_STAT, 32'h5, fifo_queue_pkg::RESP_OKAY);
    read_chk(fifo_queue_pkg::REG_IRQ_STAT, 32'h0, fifo_queue_pkg::RESP_OKAY);
    check("irq cleared", irq, 32'h0);
    check("no valid without read", rd_valid, 32'h0);
    partner.pop_burst(15, got);
    check("words read", got.size(), 15);
    foreach (got[i]) check("read order", got[i], 32'h1000 + i);
    check("nearly empty", nearly_empty_flag, 32'h1);
    partner.pop_burst(1, got);
    check("last word", {got.size() == 1, got[0]}, 32'h1100F);
    check("empty flag", {full, empty}, 32'h1);
    partner.pop_burst(1, got);
    check("underflow read", got.size(), 0);
    read_chk(fifo_queue_pkg::REG_IRQ_STAT, 32'hA, fifo_queue_pkg::RESP_OKAY);
    en <= 1'b0;
    partner.push_burst(1, 16'h2000);
    #1 check("write while disabled", {data_count, empty}, 32'h1);
    @(posedge aclk);
    en <= 1'b1;
    read_chk(8'h40, 32'h0, fifo_queue_pkg::RESP_SLVERR);
    axi_write(fifo_queue_pkg::REG_STATUS, 32'h1F, resp);
    check("read-only write response", resp, fifo_queue_pkg::RESP_SLVERR);
    axi_write(fifo_queue_pkg::REG_CTRL, 32'h1, resp);
    partner.push_burst(2, 16'hC000);
    @(posedge aclk);
    #1 check("head shown unasked", {rd_valid, rd_data}, 32'h1C000);
    partner.pop_burst(1, got);
    check("next head shown", {got.size() == 1, got[0]}, 32'h1C001);
    partner.pop_burst(1, got);
    check("drained in fall-through", {got.size() == 0, empty}, 32'h3);
    axi_write(fifo_queue_pkg::REG_CTRL, 32'h0, resp);
    partner.push_burst(3, 16'hD000);
    partner.pop_burst(1, got);
    @(posedge aclk);
    fifo_rst <= 1'b1;
    @(posedge aclk);
    fifo_rst <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 check("queue reset", {rd_data, data_count, empty}, 32'h1);
    read_chk(fifo_queue_pkg::REG_STATUS, 32'h11, fifo_queue_pkg::RESP_OKAY);
    repeat (25) @(posedge aclk);
    partner.push_burst(1, 16'hE000);
    partner.pop_burst(1, got);
    check("works after reset", {got.size() == 1, got[0]}, 32'h1E000);
    end_of_test();
  end
endmodule : configurable_fifo_queue_test
